/* File: hw/rtc_serial_slave_trim_alarm.sv */
// two-wire slave, register array, alarm compare, digital trim and cal pin
// assumes SCL and SDA_I come from pins; LINK_CLK oversamples them fast
// Function
// - steps weigh minus two or plus four ppm
// - add or skip counts in the chain
// - cal enable drives 512 Hz regardless
// - otherwise level bit releases or pulls low
// - reset: cal enable zero, level one
// - output pin is open drain only
// - alarm byte top bit enables field
// - all enabled fields equal sets flag
// - no matching while alarm function off
// - write zero clears flag, or auto-clear
// - auto-clear only after read plus STOP
// - bytes shift most significant bit first
// - SDA moves while SCL low; START/STOP
// - data pin input; ignore early START
// - STOP returns slave to idle
// - release after eight bits, ninth acks
// - ack id, address, written data bytes
// - seven bit identifier plus direction bit
// - pointer resets to zero
// - write commits at STOP, pointer stays
// - read sequence, bytes while master acks
// - pointer loads from address, increments
`timescale 1ns/1ps
module rtc_serial_slave_trim_alarm (
  // core clock and reset
  input  wire logic CORE_CLK,
  input  wire logic RST,
  // two-wire bus
  input  wire logic LINK_CLK,
  input  wire logic SCL,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE_N,
  // crystal tick and outputs
  input  wire logic OSC_32K,
  output logic      CAL_PIN_O,
  output logic      CAL_PIN_OE_N,
  output logic      SEC_TICK
);
  // ---------------------------------------------------------------
  // link reset and pin synchronisers
  // ---------------------------------------------------------------
  logic       rst_m_r, rst_l_r, rdy_m_r, rdy_s_r, rdy_core_r;
  logic [1:0] scl_m_r, sda_m_r;
  logic       scl_s_r, sda_s_r, scl_q_r, sda_q_r;
  // reset and power-up ready level brought over by two flops each
  always_ff @(posedge LINK_CLK) begin
    rst_m_r <= RST;
    rst_l_r <= rst_m_r;
    rdy_m_r <= rdy_core_r;
    rdy_s_r <= rdy_m_r;
  end
  // pins pass two sync flops, then two more; the edge stage compares the third and fourth
  always_ff @(posedge LINK_CLK) begin
    scl_m_r <= {scl_m_r[0], SCL};
    sda_m_r <= {sda_m_r[0], SDA_I};
    scl_s_r <= scl_m_r[1];
    sda_s_r <= sda_m_r[1];
    scl_q_r <= scl_s_r;
    sda_q_r <= sda_s_r;
  end
  logic scl_rise, scl_fall, start_w, stop_w;
  // SDA moving while SCL high marks START or STOP
  assign scl_rise = scl_s_r & ~scl_q_r;
  assign scl_fall = ~scl_s_r & scl_q_r;
  assign start_w  = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r & rdy_s_r;
  assign stop_w   = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
  // ---------------------------------------------------------------
  // serial slave state machine
  // ---------------------------------------------------------------
  rtc_pkg::link_st_e st_r;
  logic [7:0] shreg_r, ptr_r, wdata_r, waddr_r;
  logic [2:0] bitcnt_r;
  logic       done_r, rw_r, wpend_r, wfirst_r, sda_oe_n_r, mack_r;
  logic       arm_r, commit_w;
  logic [7:0] regs_r [0:rtc_pkg::NUM_REGS-1];
  logic       alm_flag_r, auto_clr_r, alm_set_w;
  logic [7:0] rd_byte;
  // read data: status is assembled, unmapped offsets read zero
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_r == rtc_pkg::OFS_STATUS) begin
      rd_byte[rtc_pkg::AUTOCLR_BIT] = auto_clr_r;
      rd_byte[rtc_pkg::ALMFLAG_BIT] = alm_flag_r;
    end else if (ptr_r < 8'(rtc_pkg::NUM_REGS)) begin
      rd_byte = regs_r[ptr_r[4:0]];
    end
  end
  assign commit_w = stop_w & wpend_r;
  // protocol engine: sample on SCL rise, change SDA on SCL fall
  always_ff @(posedge LINK_CLK) begin
    if (rst_l_r) begin
      st_r       <= rtc_pkg::ST_IDLE;
      shreg_r    <= 8'h00;
      bitcnt_r   <= 3'h0;
      done_r     <= 1'b0;
      rw_r       <= 1'b0;
      mack_r     <= 1'b0;
      sda_oe_n_r <= 1'b1;
      ptr_r      <= 8'h00;
      wpend_r    <= 1'b0;
      wfirst_r   <= 1'b0;
      wdata_r    <= 8'h00;
      waddr_r    <= 8'h00;
    end else if (start_w) begin
      st_r       <= rtc_pkg::ST_DEV;
      bitcnt_r   <= 3'h0;
      done_r     <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_w) begin
      st_r       <= rtc_pkg::ST_IDLE;
      sda_oe_n_r <= 1'b1;
      wpend_r    <= 1'b0;
    end else if (scl_rise) begin
      bitcnt_r <= bitcnt_r + 3'h1;
      done_r   <= (bitcnt_r == 3'h7);
      case (st_r)
        rtc_pkg::ST_DEV, rtc_pkg::ST_ADDR, rtc_pkg::ST_WDATA: begin
          shreg_r <= {shreg_r[6:0], sda_s_r};
        end
        rtc_pkg::ST_RDACK: begin
          mack_r <= ~sda_s_r;
          if (sda_s_r) begin
            st_r <= rtc_pkg::ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_r)
        rtc_pkg::ST_DEV: begin
          if (done_r && shreg_r[7:1] == rtc_pkg::SLAVE_ID) begin
            st_r       <= rtc_pkg::ST_DEVACK;
            rw_r       <= shreg_r[0];
            sda_oe_n_r <= 1'b0;
          end else if (done_r) begin
            st_r <= rtc_pkg::ST_IDLE;
          end
        end
        rtc_pkg::ST_DEVACK: begin
          bitcnt_r <= 3'h0;
          done_r   <= 1'b0;
          if (rw_r) begin
            st_r       <= rtc_pkg::ST_RDATA;
            sda_oe_n_r <= rd_byte[7];
            shreg_r    <= {rd_byte[6:0], 1'b0};
          end else begin
            st_r       <= rtc_pkg::ST_ADDR;
            sda_oe_n_r <= 1'b1;
          end
        end
        rtc_pkg::ST_ADDR, rtc_pkg::ST_WDATA: begin
          if (done_r) begin
            sda_oe_n_r <= 1'b0;
            if (st_r == rtc_pkg::ST_ADDR) begin
              st_r     <= rtc_pkg::ST_ADRACK;
              ptr_r    <= shreg_r;
              wfirst_r <= 1'b1;
            end else begin
              st_r     <= rtc_pkg::ST_WDACK;
              wpend_r  <= 1'b1;
              wfirst_r <= 1'b0;
              wdata_r  <= shreg_r;
              // later bytes step on; pointer stays on the last one
              ptr_r    <= wfirst_r ? ptr_r : ptr_r + 8'h01;
              waddr_r  <= wfirst_r ? ptr_r : ptr_r + 8'h01;
            end
          end
        end
        rtc_pkg::ST_ADRACK, rtc_pkg::ST_WDACK: begin
          st_r       <= rtc_pkg::ST_WDATA;
          sda_oe_n_r <= 1'b1;
          bitcnt_r   <= 3'h0;
          done_r     <= 1'b0;
        end
        rtc_pkg::ST_RDATA: begin
          if (done_r) begin
            st_r       <= rtc_pkg::ST_RDACK;
            sda_oe_n_r <= 1'b1;
            ptr_r      <= ptr_r + 8'h01;
          end else begin
            sda_oe_n_r <= shreg_r[7];
            shreg_r    <= {shreg_r[6:0], 1'b0};
          end
        end
        rtc_pkg::ST_RDACK: begin
          st_r       <= rtc_pkg::ST_RDATA;
          bitcnt_r   <= 3'h0;
          done_r     <= 1'b0;
          sda_oe_n_r <= rd_byte[7];
          shreg_r    <= {rd_byte[6:0], 1'b0};
        end
        default: begin
          st_r <= rtc_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // open-drain data pin: the line level only ever goes low
  assign SDA_O    = 1'b0;
  assign SDA_OE_N = sda_oe_n_r;
  // ---------------------------------------------------------------
  // register array, written only at STOP
  // ---------------------------------------------------------------
  logic ctl_tgl_r;
  always_ff @(posedge LINK_CLK) begin
    if (rst_l_r) begin
      for (int i = 0; i < rtc_pkg::NUM_REGS; i++) begin
        regs_r[i] <= rtc_pkg::REG_RST;
      end
      regs_r[rtc_pkg::OFS_TRIM[4:0]] <= rtc_pkg::TRIM_RST;
      ctl_tgl_r <= 1'b0;
    end else if (commit_w && waddr_r < 8'(rtc_pkg::NUM_REGS) &&
                 waddr_r != rtc_pkg::OFS_STATUS) begin
      regs_r[waddr_r[4:0]] <= wdata_r;
      if (waddr_r == rtc_pkg::OFS_TRIM) begin
        ctl_tgl_r <= ~ctl_tgl_r;
      end
    end
  end
  // ---------------------------------------------------------------
  // alarm compare and status flags
  // ---------------------------------------------------------------
  logic [rtc_pkg::ALM_FIELDS-1:0] fld_en, fld_eq;
  logic alm_match, alm_match_q_r;
  for (genvar g = 0; g < rtc_pkg::ALM_FIELDS; g++) begin : g_alm
    // alarm byte top bit enables; low bits match the time byte
    localparam int ALM_IDX = g + int'(rtc_pkg::OFS_ALM_FIRST);
    assign fld_en[g] = regs_r[ALM_IDX][rtc_pkg::ALM_EN_BIT];
    assign fld_eq[g] = regs_r[ALM_IDX][6:0] == regs_r[g][6:0];
  end
  assign alm_match = regs_r[rtc_pkg::OFS_INTCTL[4:0]][rtc_pkg::ALARM_FUNCTION_ENABLE_BIT]
                   & (|fld_en) & ((fld_eq | ~fld_en) == '1);
  assign alm_set_w = alm_match & ~alm_match_q_r;
  always_ff @(posedge LINK_CLK) begin
    if (rst_l_r) begin
      alm_match_q_r <= 1'b0;
    end else begin
      alm_match_q_r <= alm_match;
    end
  end
  // arm on a status read; a new START or a late alarm disarms it
  always_ff @(posedge LINK_CLK) begin
    if (rst_l_r || start_w || stop_w || alm_set_w) begin
      arm_r <= 1'b0;
    end else if (st_r == rtc_pkg::ST_RDACK && ptr_r ==
                 rtc_pkg::OFS_STATUS + 8'h01) begin
      arm_r <= 1'b1;
    end
  end
  // set wins over both the write-zero clear and the auto-clear
  always_ff @(posedge LINK_CLK) begin
    if (rst_l_r) begin
      alm_flag_r <= 1'b0;
      auto_clr_r <= 1'b0;
    end else begin
      if (alm_set_w) begin
        alm_flag_r <= 1'b1;
      end else if (commit_w && waddr_r == rtc_pkg::OFS_STATUS &&
                   !wdata_r[rtc_pkg::ALMFLAG_BIT]) begin
        alm_flag_r <= 1'b0;
      end else if (stop_w && arm_r && auto_clr_r) begin
        alm_flag_r <= 1'b0;
      end
      if (commit_w && waddr_r == rtc_pkg::OFS_STATUS) begin
        auto_clr_r <= wdata_r[rtc_pkg::AUTOCLR_BIT];
      end
    end
  end
  // ---------------------------------------------------------------
  // core domain: control byte crossing and power-up hold-off
  // ---------------------------------------------------------------
  logic [2:0] tgl_s_r;
  logic [7:0] ctl_r;
  logic [7:0] pup_cnt_r;
  // toggle handshake; the byte is stable for a whole bus frame
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tgl_s_r <= 3'h0;
      ctl_r   <= rtc_pkg::TRIM_RST;
    end else begin
      tgl_s_r <= {tgl_s_r[1:0], ctl_tgl_r};
      if (tgl_s_r[2] ^ tgl_s_r[1]) begin
        ctl_r <= regs_r[rtc_pkg::OFS_TRIM[4:0]];
      end
    end
  end
  // STARTs are ignored until the power-up count has run out
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pup_cnt_r  <= 8'h00;
      rdy_core_r <= 1'b0;
    end else if (pup_cnt_r == 8'(rtc_pkg::POWERUP_CYC - 1)) begin
      rdy_core_r <= 1'b1;
    end else begin
      pup_cnt_r <= pup_cnt_r + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // oscillator divider, digital trim, seconds tick
  // ---------------------------------------------------------------
  logic [2:0]  osc_s_r;
  logic [5:0]  cal_div_r, sec_cnt_r;
  logic [15:0] pres_r, term, steps;
  logic        osc_tick;
  assign osc_tick = osc_s_r[1] & ~osc_s_r[2];
  assign steps    = {11'h000, ctl_r[4:0]};
  // sign zero lengthens the period second, sign one shortens it
  always_comb begin
    term = rtc_pkg::OSC_PER_SEC - 16'h0001;
    if (sec_cnt_r == rtc_pkg::TRIM_PERIOD_S - 6'h01) begin
      if (ctl_r[rtc_pkg::TRIM_SIGN_BIT]) begin
        term = term - 16'(steps * rtc_pkg::TRIM_POS_STEP);
      end else begin
        term = term + 16'(steps * rtc_pkg::TRIM_NEG_STEP);
      end
    end
  end
  // count chain; one corrected second per period averages the error
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      osc_s_r   <= 3'h0;
      cal_div_r <= 6'h00;
      pres_r    <= 16'h0000;
      sec_cnt_r <= 6'h00;
      SEC_TICK  <= 1'b0;
    end else begin
      osc_s_r  <= {osc_s_r[1:0], OSC_32K};
      SEC_TICK <= 1'b0;
      if (osc_tick) begin
        cal_div_r <= cal_div_r + 6'h01;
        if (pres_r >= term) begin
          pres_r    <= 16'h0000;
          SEC_TICK  <= 1'b1;
          sec_cnt_r <= (sec_cnt_r == rtc_pkg::TRIM_PERIOD_S - 6'h01) ?
                       6'h00 : sec_cnt_r + 6'h01;
        end else begin
          pres_r <= pres_r + 16'h0001;
        end
      end
    end
  end
  // cal pin: square wave when enabled, else the level bit
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      CAL_PIN_OE_N <= 1'b1;
    end else if (ctl_r[rtc_pkg::CAL_EN_BIT]) begin
      CAL_PIN_OE_N <= cal_div_r[rtc_pkg::CAL_DIV_BIT];
    end else begin
      CAL_PIN_OE_N <= ctl_r[rtc_pkg::LEVEL_BIT];
    end
  end
  assign CAL_PIN_O = 1'b0;
  // ---------------------------------------------------------------
  // assertions and covers
  // ---------------------------------------------------------------
  AST_EARLY_START: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    (!rdy_s_r && st_r == rtc_pkg::ST_IDLE) |=> st_r == rtc_pkg::ST_IDLE)
    else $error("start taken during power-up");
  AST_STOP_IDLE: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    stop_w |=> st_r == rtc_pkg::ST_IDLE && sda_oe_n_r)
    else $error("stop did not idle the slave");
  AST_BAD_ID: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    (st_r == rtc_pkg::ST_DEV && scl_fall && done_r && !start_w && !stop_w
     && shreg_r[7:1] != rtc_pkg::SLAVE_ID) |=> sda_oe_n_r)
    else $error("acked a foreign identifier");
  AST_COMMIT: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    (commit_w && waddr_r == rtc_pkg::OFS_TRIM) |=>
    regs_r[rtc_pkg::OFS_TRIM[4:0]] == $past(wdata_r))
    else $error("write not committed at stop");
  AST_NO_EARLY_WR: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    $changed(regs_r[rtc_pkg::OFS_INTCTL[4:0]]) |-> $past(stop_w))
    else $error("register changed without stop");
  AST_PTR_INC: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    (st_r == rtc_pkg::ST_RDATA && scl_fall && done_r && !start_w && !stop_w)
    |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("read pointer did not step");
  AST_NACK_REL: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    (st_r == rtc_pkg::ST_RDACK && scl_rise && sda_s_r && !start_w
     && !stop_w) |=> sda_oe_n_r ##1 sda_oe_n_r)
    else $error("data line held after nack");
  AST_ALM_SET: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    alm_set_w |=> alm_flag_r)
    else $error("alarm match lost");
  AST_ALARM_FUNCTION_ENABLE_OFF: assert property (@(posedge LINK_CLK) disable iff (rst_l_r)
    !regs_r[rtc_pkg::OFS_INTCTL[4:0]][rtc_pkg::ALARM_FUNCTION_ENABLE_BIT] |-> !alm_match)
    else $error("match while alarm function off");
  AST_CAL_SQ: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctl_r[rtc_pkg::CAL_EN_BIT] |=>
    CAL_PIN_OE_N == $past(cal_div_r[rtc_pkg::CAL_DIV_BIT]))
    else $error("cal pin not square wave");
  AST_LEVEL: assert property (@(posedge CORE_CLK) disable iff (RST)
    !ctl_r[rtc_pkg::CAL_EN_BIT] |=>
    CAL_PIN_OE_N == $past(ctl_r[rtc_pkg::LEVEL_BIT]))
    else $error("cal pin not following level bit");
  AST_SEC_PULSE: assert property (@(posedge CORE_CLK) disable iff (RST)
    SEC_TICK |=> !SEC_TICK)
    else $error("seconds tick longer than one cycle");
  COV_READ: cover property (@(posedge LINK_CLK) disable iff (rst_l_r)
    st_r == rtc_pkg::ST_RDACK && mack_r);
  COV_WRITE: cover property (@(posedge LINK_CLK) disable iff (rst_l_r)
    commit_w);
  COV_ALARM: cover property (@(posedge LINK_CLK) disable iff (rst_l_r)
    alm_set_w);
endmodule

/* File: hw/rtc_pkg.sv */
// constants, register map and state codes of the calendar clock bus slice
// assumes the map holds 18 byte registers starting at index zero
package rtc_pkg;
  // ---------------------------------------------------------------
  // bus identity and map
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ID      = 7'h2C; // arbitrary value
  localparam logic [7:0] OFS_TRIM      = 8'h07;
  localparam logic [7:0] OFS_INTCTL    = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0B;
  localparam logic [7:0] OFS_ALM_FIRST = 8'h0C;
  localparam int         NUM_REGS      = 18;
  localparam int         ALM_FIELDS    = 6;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         TRIM_SIGN_BIT = 5;
  localparam int         CAL_EN_BIT    = 6;
  localparam int         LEVEL_BIT     = 7;
  localparam int         ALARM_FUNCTION_ENABLE_BIT      = 6;
  localparam int         AUTOCLR_BIT   = 7;
  localparam int         ALMFLAG_BIT   = 2;
  localparam int         ALM_EN_BIT    = 7;
  localparam logic [7:0] TRIM_RST      = 8'h80;
  localparam logic [7:0] REG_RST       = 8'h00;
  // ---------------------------------------------------------------
  // oscillator, trim and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] OSC_PER_SEC   = 16'h8000;
  localparam int          CAL_DIV_BIT   = 5;  // 32768 / 64 = 512 Hz
  localparam logic [15:0] TRIM_NEG_STEP = 16'h0004;
  localparam logic [15:0] TRIM_POS_STEP = 16'h0008;
  localparam logic [5:0]  TRIM_PERIOD_S = 6'h3C;
  localparam int          CORE_CLK_HZ   = 10_000_000;
  localparam int          POWERUP_US    = 10;
  localparam int          POWERUP_CYC   =
    (POWERUP_US * CORE_CLK_HZ + 999_999) / 1_000_000;
  // ---------------------------------------------------------------
  // serial slave states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_DEV    = 4'b0001,
    ST_DEVACK = 4'b0010,
    ST_ADDR   = 4'b0011,
    ST_ADRACK = 4'b0100,
    ST_WDATA  = 4'b0101,
    ST_WDACK  = 4'b0110,
    ST_RDATA  = 4'b0111,
    ST_RDACK  = 4'b1000
  } link_st_e;
endpackage

/* File: verif/two_wire_master.sv */
// behavioural two-wire bus master that stands on the far side of the slave
// assumes an open-drain data line with a pull-up, resolved by the testbench
`timescale 1ns/1ps
module two_wire_master (
  // clock that paces the bus
  input  wire logic core_clk,
  // bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  // bus idles released and high
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  // ---------------------------------------------------------------
  // bit and byte level
  // ---------------------------------------------------------------
  // one bit: data moves only while the clock is low, sampled mid-high
  task automatic xfer(input logic b, output logic s);
    sda_rel <= b;
    @(posedge core_clk);
    scl <= 1'b1;
    @(posedge core_clk);
    s = sda;
    @(posedge core_clk);
    scl <= 1'b0;
    @(posedge core_clk);
  endtask
  // data high before clock rises, so a repeated start is clean too
  task automatic start();
    sda_rel <= 1'b1;
    @(posedge core_clk);
    scl <= 1'b1;
    @(posedge core_clk);
    sda_rel <= 1'b0;
    @(posedge core_clk);
    scl <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic stop();
    sda_rel <= 1'b0;
    @(posedge core_clk);
    scl <= 1'b1;
    @(posedge core_clk);
    sda_rel <= 1'b1;
    @(posedge core_clk);
  endtask
  // eight bits out, then release for the slave's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], s);
    end
    xfer(1'b1, s);
    ack = (s === 1'b0);
  endtask
  // eight bits in, then ack to continue or nack before stop
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    xfer(~ack, s);
  endtask
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the calendar clock bus slice
// assumes the two-wire master model drives the bus; pins have pull-ups
`timescale 1ns/1ps
module testbench;
  logic       core_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst      = 1'b1;
  logic       osc      = 1'b0;
  int         osc_cnt  = 0;
  int         bad_count   = 0;
  int         comparisons = 0;
  logic       scl;
  logic       sda_rel;
  logic       sda_o;
  logic       sda_oe_n;
  logic       cal_o;
  logic       cal_oe_n;
  logic       sec_tick;
  wire        sda     = sda_rel & (sda_oe_n | sda_o);
  wire        cal_pin = cal_oe_n | cal_o;
  logic [6:0] id      = rtc_pkg::SLAVE_ID;

  // ---------------------------------------------------------------
  // clocks, crystal tick and instances
  // ---------------------------------------------------------------
  initial forever #50 core_clk = ~core_clk;
  initial forever #3 link_clk = ~link_clk;
  // crystal tick sped up to 20 core cycles so 512 Hz phases stay short
  always @(posedge core_clk) begin
    osc_cnt <= (osc_cnt == 9) ? 0 : osc_cnt + 1;
    if (osc_cnt == 9) begin
      osc <= ~osc;
    end
  end
  two_wire_master m (.core_clk(core_clk), .sda(sda), .scl(scl),
                     .sda_rel(sda_rel));
  rtc_serial_slave_trim_alarm uut (
    .CORE_CLK(core_clk), .RST(rst), .LINK_CLK(link_clk), .SCL(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .OSC_32K(osc),
    .CAL_PIN_O(cal_o), .CAL_PIN_OE_N(cal_oe_n), .SEC_TICK(sec_tick));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic k;
    m.start();
    m.wbyte({id, 1'b0}, k);
    check({7'h00, k}, 8'h01);
    m.wbyte(a, k);
    check({7'h00, k}, 8'h01);
    m.wbyte(d, k);
    check({7'h00, k}, 8'h01);
    m.stop();
  endtask
  // random read of one byte, ended by nack and stop
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic       k;
    logic [7:0] d;
    m.start();
    m.wbyte({id, 1'b0}, k);
    m.wbyte(a, k);
    m.start();
    m.wbyte({id, 1'b1}, k);
    check({7'h00, k}, 8'h01);
    m.rbyte(1'b0, d);
    m.stop();
    check(d, exp);
  endtask
  // current-address read of n bytes; last one nacked
  task automatic cur_read(input int n, input logic [7:0] last);
    logic       k;
    logic [7:0] d;
    m.start();
    m.wbyte({id, 1'b1}, k);
    check({7'h00, k}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i != n - 1, d);
      check(d, (i == n - 1) ? last : 8'h00);
    end
    m.stop();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // a start right after reset falls in the power-up window
  task automatic t_powerup();
    logic k;
    m.start();
    m.wbyte({id, 1'b0}, k);
    check({7'h00, k}, 8'h00);
    m.stop();
    repeat (150) @(posedge core_clk);
    check({7'h00, cal_pin}, 8'h01);
  endtask
  // pointer starts at zero: eighth byte is the trim register default
  task automatic t_pointer();
    cur_read(8, rtc_pkg::TRIM_RST);
  endtask
  // foreign identifier gets no ack; a later good write is still acked and unmapped offset 12h reads zero
  task automatic t_bad_id();
    logic k;
    m.start();
    m.wbyte({id ^ 7'h01, 1'b0}, k);
    check({7'h00, k}, 8'h00);
    m.stop();
    wreg(8'h12, 8'h55);
    rchk(8'h12, 8'h00);
  endtask
  // level pin low, pointer kept at the written address, then released
  task automatic t_level();
    wreg(rtc_pkg::OFS_TRIM, 8'h3F);
    repeat (20) @(posedge core_clk);
    check({7'h00, cal_pin}, 8'h00);
    cur_read(1, 8'h3F);
    wreg(rtc_pkg::OFS_TRIM, 8'h80);
    repeat (20) @(posedge core_clk);
    check({7'h00, cal_pin}, 8'h01);
  endtask
  // 512 Hz: one half period is 32 crystal ticks of 20 core cycles
  task automatic t_cal_out();
    int n;
    wreg(rtc_pkg::OFS_TRIM, 8'h40);
    n = 0;
    while (cal_pin !== 1'b0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    while (cal_pin !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    while (cal_pin === 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    check({7'h00, n >= 600 && n <= 680}, 8'h01);
    check({7'h00, cal_o}, 8'h00);
  endtask
  // alarm: gated by function enable, field enable, manual and auto clear
  task automatic t_alarm();
    wreg(8'h00, 8'h15);
    wreg(rtc_pkg::OFS_ALM_FIRST, 8'h95);
    rchk(rtc_pkg::OFS_STATUS, 8'h00);
    wreg(rtc_pkg::OFS_INTCTL, 8'h40);
    rchk(rtc_pkg::OFS_STATUS, 8'h04);
    wreg(rtc_pkg::OFS_STATUS, 8'h00);
    rchk(rtc_pkg::OFS_STATUS, 8'h00);
    wreg(rtc_pkg::OFS_STATUS, 8'h80);
    wreg(rtc_pkg::OFS_ALM_FIRST, 8'h15);
    rchk(rtc_pkg::OFS_STATUS, 8'h80);
    wreg(rtc_pkg::OFS_ALM_FIRST, 8'h95);
    rchk(rtc_pkg::OFS_STATUS, 8'h84);
    rchk(rtc_pkg::OFS_STATUS, 8'h80);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_powerup();
    t_pointer();
    t_bad_id();
    t_level();
    t_cal_out();
    t_alarm();
    summarize();
  end
  // whole run needs about 5k cycles; twelve times that means a hang
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    summarize();
  end
endmodule
